// file: test_transceiver_module_mgmt_control.sv
// Self-checking testbench of the management and control block.
`timescale 1ns/1ps
module test_transceiver_module_mgmt_control;
   localparam int TXE = 0, PD = 1, NR = 2, LOS = 3, INTR = 4;
   logic i_clk = 1'b0, i_rstn = 1'b0, txdis = 1'b0, pdown = 1'b0, desel = 1'b0;
   logic fault = 1'b0, sig = 1'b1;
   logic [7:0] diag = 8'h00, d1, d2;
   logic o_sda_out, o_sda_oe, o_tx_enable, o_powered_down, o_nr, o_los, o_interrupt;
   logic scl, h_oe, h_done, sda;
   logic [8:0] h_res;
   logic [8:0] exp_q[$];
   logic [31:0] lfsr = 32'hAD03E992;
   int errors = 0, checks_done = 0, cycles = 0, n;
   // -----------------------------------------------------------
   // Clock, open-drain wire and design.
   // -----------------------------------------------------------
   always #5 i_clk = !i_clk;
   assign sda = !(h_oe | o_sda_oe);
   tmmc_top #(.INIT_CYCLES(20)) u_tmmc_top (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_transmit_disable_in(txdis), .i_pdown_rst(pdown), .i_module_deselect_in(desel),
      .i_module_fault(fault), .i_signal_present(sig), .i_diag_value(diag), .i_scl(scl),
      .i_sda(sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_tx_enable(o_tx_enable),
      .o_powered_down(o_powered_down), .o_module_not_ready_out(o_nr),
      .o_receive_signal_loss_out(o_los), .o_interrupt(o_interrupt));
   tmmc_host_model u_tmmc_host_model (.i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe),
      .o_done(h_done), .o_result(h_res));
   // -----------------------------------------------------------
   // Helpers.
   // -----------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   function automatic logic out_sel(input int k);
      case (k)
         TXE: return o_tx_enable;
         PD: return o_powered_down;
         NR: return o_nr;
         LOS: return o_los;
         default: return o_interrupt;
      endcase
   endfunction
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits a bounded number of cycles for an output level, then compares it.
   task automatic expect_out(input int k, input logic v, input int max);
      n = 0;
      while (out_sel(k) !== v && n < max) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check({8'h00, out_sel(k)}, {8'h00, v});
   endtask
   // Notes the expected result, then runs the transfer on the host model.
   task automatic xact(input logic wr, input logic [7:0] p, input logic [7:0] d,
                       input logic [8:0] e);
      exp_q.push_back(e);
      u_tmmc_host_model.access(wr, p, d);
      repeat (20) @(posedge i_clk);
   endtask
   task automatic finish_test();
      $display("Checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Scoreboard: each finished transfer is compared with the oldest note.
   always @(posedge h_done) begin
      check(h_res, exp_q.pop_front());
   end
   // Cuts a hang short.
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 80000) begin
         errors++;
         finish_test();
      end
   end
   // -----------------------------------------------------------
   // Main sequence.
   // -----------------------------------------------------------
   initial begin
      repeat (9) @(posedge i_clk);
      #1;
      for (int k = 0; k < 5; k++) begin
         check({8'h00, out_sel(k)}, {8'h00, k == NR || k == LOS});
      end
      check({8'h00, o_sda_out}, 9'h000);
      @(posedge i_clk) i_rstn <= 1'b1;
      expect_out(NR, 1'b0, 100);
      expect_out(TXE, 1'b1, 10);
      expect_out(LOS, 1'b0, 10000);
      @(posedge i_clk) txdis <= 1'b1;
      expect_out(TXE, 1'b0, 1000);
      xact(1'b0, 8'h01, 8'h00, 9'h101);
      @(posedge i_clk) txdis <= 1'b0;
      expect_out(TXE, 1'b1, 1000);
      @(posedge i_clk) sig <= 1'b0;
      expect_out(LOS, 1'b1, 10000);
      expect_out(INTR, 1'b1, 10);
      @(posedge i_clk) sig <= 1'b1;
      repeat (100) @(posedge i_clk);
      sig <= 1'b0;
      repeat (10) @(posedge i_clk);
      check({8'h00, o_los}, 9'h001);
      sig <= 1'b1;
      expect_out(LOS, 1'b0, 10000);
      check({8'h00, n >= tmmc_pkg::LOS_OFF_MIN_CYC}, 9'h001);
      check({8'h00, o_interrupt}, 9'h001);
      xact(1'b0, 8'h00, 8'h00, 9'h101);
      expect_out(INTR, 1'b0, 50000);
      @(posedge i_clk) fault <= 1'b1;
      expect_out(NR, 1'b1, 10000);
      expect_out(INTR, 1'b1, 10);
      xact(1'b0, 8'h00, 8'h00, 9'h102);
      expect_out(INTR, 1'b0, 50000);
      @(posedge i_clk) fault <= 1'b0;
      expect_out(NR, 1'b0, 10000);
      lfsr = lfsr_next(lfsr);
      d1 = lfsr[7:0];
      d2 = lfsr[15:8];
      @(posedge i_clk) diag <= lfsr[23:16];
      xact(1'b0, 8'h02, 8'h00, {1'b1, lfsr[23:16]});
      xact(1'b1, 8'h10, d1, {1'b1, d1});
      xact(1'b1, 8'h80, d2, {1'b1, d2});
      xact(1'b0, 8'h10, 8'h00, {1'b1, d1});
      xact(1'b0, 8'h80, 8'h00, {1'b1, d2});
      @(posedge i_clk) desel <= 1'b1;
      repeat (10) @(posedge i_clk);
      xact(1'b0, 8'h10, 8'h00, 9'h0FF);
      desel <= 1'b0;
      repeat (10) @(posedge i_clk);
      xact(1'b0, 8'h10, 8'h00, {1'b1, d1});
      sig <= 1'b0;
      expect_out(INTR, 1'b1, 10000);
      @(posedge i_clk) pdown <= 1'b1;
      expect_out(PD, 1'b1, 10000);
      expect_out(TXE, 1'b0, 10);
      @(posedge i_clk) sig <= 1'b1;
      repeat (1100) @(posedge i_clk);
      pdown <= 1'b0;
      expect_out(NR, 1'b0, 1000);
      expect_out(PD, 1'b0, 10);
      expect_out(INTR, 1'b0, 10);
      finish_test();
   end
endmodule

// file: tmmc_host_model.sv
// Behavioural host two-wire master for the management port.
`timescale 1ns/1ps
module tmmc_host_model #(
   parameter logic [6:0] DEV_ADDR = tmmc_pkg::TWI_DEV_ADDR
) (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe,
   output logic o_done,
   output logic [8:0] o_result
);
   localparam time Q = 40ns;
   // SCL stands high and SDA is released between frames.
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
      o_done = 1'b0;
      o_result = 9'h000;
   end
   // One bit in a 160 ns period: set while low, sampled mid high.
   task automatic bit_io(input logic b, output logic s);
      o_sda_oe = !b;
      #Q o_scl = 1'b1;
      #Q s = i_sda;
      #Q o_scl = 1'b0;
      #Q;
   endtask
   // Start or repeated start: SDA falls while SCL is high.
   task automatic start_cond();
      o_sda_oe = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b1;
      #Q o_scl = 1'b0;
      #Q;
   endtask
   // Stop: SDA rises while SCL is high.
   task automatic stop_cond();
      o_sda_oe = 1'b1;
      #Q o_scl = 1'b1;
      #Q o_sda_oe = 1'b0;
      #Q;
   endtask
   // Eight bits, then the ninth, which is an answer bit or our own not-acknowledge.
   task automatic byte_io(input logic [7:0] d, input logic b9, output logic [7:0] r,
                          output logic s9);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(b9, s9);
   endtask
   // Single byte write or pointer-set then read; result is {all acked, byte}.
   task automatic access(input logic wr, input logic [7:0] ptr, input logic [7:0] wd);
      logic [7:0] r;
      logic a0, a1, a2, nk;
      // Step off the system clock edge so no bus change races a sampling edge.
      #3;
      start_cond();
      byte_io({DEV_ADDR, 1'b0}, 1'b1, r, a0);
      byte_io(ptr, 1'b1, r, a1);
      if (wr) begin
         byte_io(wd, 1'b1, r, a2);
      end else begin
         start_cond();
         byte_io({DEV_ADDR, 1'b1}, 1'b1, r, a2);
         byte_io(8'hFF, 1'b1, r, nk);
      end
      stop_cond();
      o_result = {!(a0 | a1 | a2), (wr ? wd : r)};
      o_done = 1'b1;
      #5 o_done = 1'b0;
   endtask
endmodule

// file: tmmc_pkg.sv
// Shared constants of the transceiver module management and control block.
package tmmc_pkg;
   // ----------------------------------------------------------------
   // Clock rate and documented times, each in its own unit.
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int T_TX_OFF_US = 10;
   localparam int T_TX_ON_MS = 2;
   localparam int T_INIT_MS = 300;
   localparam int T_INT_ON_MS = 200;
   localparam int T_INT_OFF_US = 500;
   localparam int T_PDN_ON_US = 100;
   localparam int T_PDN_OFF_MS = 300;
   localparam int T_RESET_MIN_US = 10;
   localparam int T_NR_MS = 1;
   localparam int T_DESEL_MS = 2;
   localparam int T_LOS_ON_US = 100;
   localparam int T_LOS_OFF_MIN_NS = 2300;
   localparam int T_LOS_OFF_MAX_US = 100;
   localparam int F_SCL_MAX_KHZ = 400;
   localparam int T_INIT_RUN_US = 1000;

   // ----------------------------------------------------------------
   // Cycle counts derived from the times (least times round up).
   // ----------------------------------------------------------------
   localparam int RESET_MIN_CYC = T_RESET_MIN_US * CLK_MHZ;
   localparam int LOS_OFF_MIN_CYC = (T_LOS_OFF_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int INIT_RUN_CYC = T_INIT_RUN_US * CLK_MHZ;
   localparam int INIT_MAX_CYC = T_INIT_MS * 1000 * CLK_MHZ;

   // ----------------------------------------------------------------
   // Two-wire address space layout.
   // ----------------------------------------------------------------
   localparam int SPACE_BYTES = 256;
   localparam int BLOCK_BYTES = 128;
   localparam logic [7:0] FLAG_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h01;
   localparam int FLAG_LOS_BIT = 0;
   localparam int FLAG_FAULT_BIT = 1;
   localparam logic [1:0] FLAG_RESET = 2'h0;
   localparam logic [6:0] TWI_DEV_ADDR = 7'h50;
endpackage

// file: tmmc_top.sv
// Management and control logic of a pluggable optical transceiver module.
`timescale 1ns/1ps
// Behaviour
// RL1 - Transmit disable rising edge turns the laser off within 10 us.
// RL2 - Transmit disable falling edge restores the laser within 2 ms.
// RL3 - Initialization after power-on finishes within 300 ms.
// RL4 - A trigger condition raises the interrupt output within 200 ms.
// RL5 - Reading the flags clears them; interrupt drops within 500 us.
// RL6 - Power-down request puts the module in power-down within 100 us.
// RL7 - After power-down negation, power-up and reset finish within 300 ms.
// RL8 - Host holds power-down at least 10 us to get the initial reset.
// RL9 - A module fault raises the not-ready output within 1 ms.
// RL10 - Reaching ready drops the not-ready output within 1 ms.
// RL11 - Deselect stops two-wire responses within 2 ms.
// RL12 - Reselect restores two-wire responses within 2 ms.
// RL13 - Loss of received signal raises the signal-loss output within 100 us.
// RL14 - Signal return drops signal-loss no sooner than 2.3 us, within 100 us.
// RL15 - Serial clock runs from standstill up to 400 kHz; all rates work.
// RL16 - Two-wire space is 256 bytes in two 128-byte blocks.
// RL17 - Lower block is always reachable and holds live diagnostics.
// RL18 - Upper block holds identification, user storage and other tables.
// RL19 - Interrupt stays asserted until the latched flags are read.
module tmmc_top #(
   parameter int INIT_CYCLES = tmmc_pkg::INIT_RUN_CYC,
   parameter logic [6:0] DEV_ADDR = tmmc_pkg::TWI_DEV_ADDR
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_transmit_disable_in,
   input wire logic i_pdown_rst,
   input wire logic i_module_deselect_in,
   input wire logic i_module_fault,
   input wire logic i_signal_present,
   input wire logic [7:0] i_diag_value,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic o_tx_enable,
   output logic o_powered_down,
   output logic o_module_not_ready_out,
   output logic o_receive_signal_loss_out,
   output logic o_interrupt
);
   // ----------------------------------------------------------------
   // Reset release and input synchronisers.
   // ----------------------------------------------------------------
   localparam int NSYNC = 7;
   localparam int INIT_W = $clog2(INIT_CYCLES + 1);
   localparam int PDN_W = $clog2(tmmc_pkg::RESET_MIN_CYC + 1);
   localparam int LOS_W = $clog2(tmmc_pkg::LOS_OFF_MIN_CYC + 1);
   localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);
   localparam logic [PDN_W-1:0] PDN_LAST = PDN_W'(tmmc_pkg::RESET_MIN_CYC - 1);
   localparam logic [PDN_W-1:0] PDN_DONE = PDN_W'(tmmc_pkg::RESET_MIN_CYC);
   localparam logic [LOS_W-1:0] LOS_DONE = LOS_W'(tmmc_pkg::LOS_OFF_MIN_CYC);

   typedef enum {ST_INIT, ST_READY, ST_PDOWN} tmmc_state_t;

   logic rst_q1, rst_n;
   logic [NSYNC-1:0] raw_in, sync1, sync2;
   logic txdis_s, pdn_s, desel_s, fault_s, sig_s, scl_s, sda_s;

   // Reset is taken at once and released through two flip-flops.
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   assign raw_in = {i_sda, i_scl, i_signal_present, i_module_fault, i_module_deselect_in,
                    i_pdown_rst, i_transmit_disable_in};

   // Each of the seven control and bus pins passes two flip-flops; only the second stage is read.
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
               sync1[gi] <= (gi >= 5) ? 1'b1 : 1'b0;
               sync2[gi] <= (gi >= 5) ? 1'b1 : 1'b0;
            end else begin
               sync1[gi] <= raw_in[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate

   assign {sda_s, scl_s, sig_s, fault_s, desel_s, pdn_s, txdis_s} = sync2;

   // ----------------------------------------------------------------
   // Power, initialization and pin control.
   // ----------------------------------------------------------------
   tmmc_state_t st, next_st;
   logic [INIT_W-1:0] init_cnt, next_init_cnt;
   logic [PDN_W-1:0] pdn_cnt, next_pdn_cnt;
   logic [LOS_W-1:0] los_cnt, next_los_cnt;
   logic next_tx, next_nr, next_los, pdn_reset, los_q, fault_q;
   logic [1:0] flags, next_flags, flag_set, flag_clr;
   logic tw_wr, tw_rd;
   logic [7:0] tw_ptr, tw_addr, tw_data, rdata;

   // A long enough power-down hold resets the latched interrupt flags.
   assign pdn_reset = pdn_s && (pdn_cnt == PDN_LAST); // RL8

   // Next values of the power state, pins and loss-of-signal filter.
   always_comb begin
      next_st = st;
      next_init_cnt = init_cnt;
      next_pdn_cnt = pdn_s ? ((pdn_cnt == PDN_DONE) ? pdn_cnt : pdn_cnt + PDN_W'(1)) : '0;
      case (st)
         ST_INIT: begin
            if (pdn_s) begin
               next_st = ST_PDOWN; // RL6
            end else if (init_cnt == INIT_LAST) begin
               next_st = ST_READY; // RL3
            end else begin
               next_init_cnt = init_cnt + INIT_W'(1);
            end
         end
         ST_READY: begin
            if (pdn_s) begin
               next_st = ST_PDOWN; // RL6
            end
         end
         ST_PDOWN: begin
            if (!pdn_s) begin
               next_st = ST_INIT; // RL7
               next_init_cnt = '0;
            end
         end
         default: begin
            next_st = ST_INIT;
         end
      endcase
      next_tx = (st == ST_READY) && !txdis_s && !fault_s; // RL1 RL2
      next_nr = (st != ST_READY) || fault_s; // RL9 RL10
      if (!sig_s) begin
         next_los = 1'b1; // RL13
         next_los_cnt = '0;
      end else if (los_cnt == LOS_DONE) begin
         next_los = 1'b0; // RL14
         next_los_cnt = los_cnt;
      end else begin
         next_los = o_receive_signal_loss_out;
         next_los_cnt = los_cnt + LOS_W'(1);
      end
   end

   // Registers of the power state, pins and loss-of-signal filter.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_INIT;
         init_cnt <= '0;
         pdn_cnt <= '0;
         los_cnt <= '0;
         o_tx_enable <= 1'b0;
         o_module_not_ready_out <= 1'b1;
         o_receive_signal_loss_out <= 1'b1;
      end else begin
         st <= next_st;
         init_cnt <= next_init_cnt;
         pdn_cnt <= next_pdn_cnt;
         los_cnt <= next_los_cnt;
         o_tx_enable <= next_tx;
         o_module_not_ready_out <= next_nr;
         o_receive_signal_loss_out <= next_los;
      end
   end

   assign o_powered_down = (st == ST_PDOWN);

   // ----------------------------------------------------------------
   // Latched interrupt flags, cleared by reading them.
   // ----------------------------------------------------------------
   assign flag_set = {fault_s & ~fault_q, o_receive_signal_loss_out & ~los_q}; // RL4
   assign flag_clr = (tw_rd && tw_addr == tmmc_pkg::FLAG_OFS) ? tw_data[1:0] : 2'h0;

   // Only bits that were read are cleared, and a new event wins over the clear.
   always_comb begin
      next_flags = (flags & ~flag_clr) | flag_set; // RL5 RL19
      if (pdn_reset) begin
         next_flags = tmmc_pkg::FLAG_RESET; // RL8
      end
   end

   // Registers of the flags and their edge detectors.
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= tmmc_pkg::FLAG_RESET;
         los_q <= 1'b1; // Matches the reset level of signal loss, so no false edge.
         fault_q <= 1'b0;
      end else begin
         flags <= next_flags;
         los_q <= o_receive_signal_loss_out;
         fault_q <= fault_s;
      end
   end

   assign o_interrupt = |flags;

   // ----------------------------------------------------------------
   // Two-wire port and its 256-byte space.
   // ----------------------------------------------------------------
   logic [7:0] mem [0:tmmc_pkg::SPACE_BYTES-1];

   // The slave is held idle while deselected and resumes when selected.
   tmmc_twi_slave #(
      .DEV_ADDR(DEV_ADDR)
   ) u_twi (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_enable(!desel_s), // RL11 RL12
      .i_scl(scl_s), // RL15
      .i_sda(sda_s),
      .i_rdata(rdata),
      .o_sda_oe(o_sda_oe),
      .o_wr(tw_wr),
      .o_rd(tw_rd),
      .o_ptr(tw_ptr),
      .o_addr(tw_addr),
      .o_data(tw_data)
   );

   assign o_sda_out = 1'b0;

   // Lower block leads with live flags, status and diagnostics; the rest is table storage.
   always_comb begin
      case (tw_ptr)
         tmmc_pkg::FLAG_OFS: rdata = {6'h00, flags}; // RL17
         tmmc_pkg::STAT_OFS: rdata = {3'h0, o_powered_down, o_module_not_ready_out,
                                      o_receive_signal_loss_out, o_tx_enable, txdis_s};
         8'h02: rdata = i_diag_value; // RL17
         default: rdata = mem[tw_ptr]; // RL16 RL18
      endcase
   end

   // Host writes land in both blocks; live locations are read-only.
   always_ff @(posedge i_clk) begin
      if (tw_wr && tw_addr > 8'h02) begin
         mem[tw_addr] <= tw_data; // RL18
      end
   end

   // ----------------------------------------------------------------
   // Checks of the documented timing.
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   sequence s_flag_read;
      tw_rd && tw_addr == tmmc_pkg::FLAG_OFS && flag_set == 2'h0;
   endsequence

   a_tx_off_delay: assert property ($rose(txdis_s) |=> !o_tx_enable) // RL1
      else $error("laser still on after transmit disable");
   a_tx_on_delay: assert property ((st == ST_READY && !txdis_s && !fault_s) |=> o_tx_enable) // RL2
      else $error("laser not restored");
   a_init_finish: assert property ((st == ST_INIT && !pdn_s && init_cnt == INIT_LAST)
                                   |=> st == ST_READY) // RL3 RL7
      else $error("initialization did not finish");
   a_int_assert: assert property ($rose(o_receive_signal_loss_out) |-> ##[1:2] o_interrupt) // RL4
      else $error("interrupt not raised");
   a_int_clear: assert property (s_flag_read |=> flags == ($past(flags) & ~$past(flag_clr))) // RL5
      else $error("flags not cleared by read");
   a_int_hold: assert property (o_interrupt && !tw_rd && !pdn_reset |=> o_interrupt) // RL19
      else $error("interrupt dropped without read");
   a_pdown_entry: assert property ($rose(pdn_s) |-> ##[1:2] o_powered_down) // RL6
      else $error("power-down not entered");
   a_pdown_reset: assert property (pdn_reset |=> flags == tmmc_pkg::FLAG_RESET) // RL8
      else $error("held power-down did not reset flags");
   a_nr_fault: assert property ($rose(fault_s) |=> o_module_not_ready_out) // RL9
      else $error("not-ready missing on fault");
   a_nr_ready: assert property ((st == ST_READY && !fault_s) |=> !o_module_not_ready_out) // RL10
      else $error("not-ready stuck");
   a_desel_quiet: assert property (desel_s |=> !o_sda_oe) // RL11
      else $error("response while deselected");
   a_los_assert: assert property (!sig_s |=> o_receive_signal_loss_out) // RL13
      else $error("signal loss not flagged");
   a_los_negate: assert property ($fell(o_receive_signal_loss_out)
                                  |-> $past(sig_s) && $past(los_cnt) == LOS_DONE) // RL14
      else $error("signal loss negated early");
endmodule

// file: tmmc_twi_slave.sv
// Two-wire serial slave with byte pointer for the management address space.
`timescale 1ns/1ps
module tmmc_twi_slave #(
   parameter logic [6:0] DEV_ADDR = tmmc_pkg::TWI_DEV_ADDR
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [7:0] i_rdata,
   output logic o_sda_oe,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_ptr,
   output logic [7:0] o_addr,
   output logic [7:0] o_data
);
   typedef enum {TW_IDLE, TW_DEV, TW_PTR, TW_WDATA, TW_ACK, TW_RDATA, TW_RACK} tmmc_tw_t;
   tmmc_tw_t st, next_st, after, next_after;
   logic [3:0] cnt, next_cnt;
   logic [7:0] sr, next_sr, ptr, next_ptr, next_addr, next_data;
   logic oe, next_oe, scl_d, sda_d, next_wr, next_rd;
   logic scl_rise, scl_fall, start, stop;

   assign o_sda_oe = oe;
   assign o_ptr = ptr;

   // Bus events seen on the already synchronised lines.
   assign scl_rise = i_scl & ~scl_d;
   assign scl_fall = ~i_scl & scl_d;
   assign start = scl_d & i_scl & sda_d & ~i_sda;
   assign stop = scl_d & i_scl & ~sda_d & i_sda;

   // Next state of the byte engine; only bus edges and the enable move it, so any rate works.
   always_comb begin
      next_st = st;
      next_after = after;
      next_cnt = cnt;
      next_sr = sr;
      next_ptr = ptr;
      next_oe = oe;
      next_wr = 1'b0;
      next_rd = 1'b0;
      next_addr = o_addr;
      next_data = o_data;
      if (!i_enable || stop) begin
         next_st = TW_IDLE;
         next_oe = 1'b0;
      end else if (start) begin
         next_st = TW_DEV;
         next_cnt = 4'h0;
         next_oe = 1'b0;
      end else begin
         case (st)
            TW_DEV, TW_PTR, TW_WDATA: begin
               if (scl_rise && cnt != 4'h8) begin
                  next_sr = {sr[6:0], i_sda};
                  next_cnt = cnt + 4'h1;
               end else if (scl_fall && cnt == 4'h8) begin
                  next_cnt = 4'h0;
                  next_oe = 1'b1;
                  next_st = TW_ACK;
                  if (st == TW_DEV) begin
                     if (sr[7:1] != DEV_ADDR) begin
                        next_oe = 1'b0;
                        next_st = TW_IDLE;
                     end
                     next_after = sr[0] ? TW_RDATA : TW_PTR;
                  end else if (st == TW_PTR) begin
                     next_ptr = sr;
                     next_after = TW_WDATA;
                  end else begin
                     next_wr = 1'b1;
                     next_addr = ptr;
                     next_data = sr;
                     next_ptr = ptr + 8'h01;
                  end
               end
            end
            TW_ACK: begin
               if (scl_fall) begin
                  next_oe = 1'b0;
                  next_st = after;
                  next_cnt = 4'h0;
                  if (after == TW_RDATA) begin
                     next_sr = i_rdata;
                     next_rd = 1'b1;
                     next_addr = ptr;
                     next_data = i_rdata;
                     next_ptr = ptr + 8'h01;
                     next_oe = ~i_rdata[7];
                  end
               end
            end
            TW_RDATA: begin
               if (scl_rise) begin
                  next_cnt = cnt + 4'h1;
               end else if (scl_fall) begin
                  if (cnt == 4'h8) begin
                     next_oe = 1'b0;
                     next_st = TW_RACK;
                  end else begin
                     next_sr = {sr[6:0], 1'b0};
                     next_oe = ~sr[6];
                  end
               end
            end
            TW_RACK: begin
               if (scl_rise) begin
                  next_st = i_sda ? TW_IDLE : TW_ACK;
                  next_after = TW_RDATA;
               end
            end
            TW_IDLE: begin
               next_oe = 1'b0;
            end
            default: begin
               next_st = TW_IDLE;
            end
         endcase
      end
   end

   // Registers of the byte engine.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= TW_IDLE;
         after <= TW_PTR;
         cnt <= 4'h0;
         sr <= 8'h00;
         ptr <= 8'h00;
         oe <= 1'b0;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         o_wr <= 1'b0;
         o_rd <= 1'b0;
         o_addr <= 8'h00;
         o_data <= 8'h00;
      end else begin
         st <= next_st;
         after <= next_after;
         cnt <= next_cnt;
         sr <= next_sr;
         ptr <= next_ptr;
         oe <= next_oe;
         scl_d <= i_scl;
         sda_d <= i_sda;
         o_wr <= next_wr;
         o_rd <= next_rd;
         o_addr <= next_addr;
         o_data <= next_data;
      end
   end
endmodule
